// ==== hdl/pcoc_clk_div.sv ====
// Purpose: clock output post divider, toggles on every n-th main clock rise
// Assumes: main clock level sampled synchronously to pclk
// Notes: output frequency is main clock / (2 * n); n of zero holds low
`timescale 1ns/1ps
`default_nettype none

module pcoc_clk_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic en,
  input wire logic [3:0] div,
  // source and result
  input wire logic src,
  output logic out_q
);

  logic src_q;
  logic [3:0] cnt_q;
  logic src_rise;

  assign src_rise = src & ~src_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      out_q <= 1'b0;
    end else if (!en || div == 4'h0) begin
      // disabled output parks low so the pin never glitches high
      cnt_q <= 4'h0;
      out_q <= 1'b0;
    end else if (src_rise) begin
      if (cnt_q >= div - 4'h1) begin
        cnt_q <= 4'h0;
        out_q <= ~out_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hdl/pcoc_defs.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb byte addresses, pclk at 40 MHz
// Notes: definitions only
`ifndef PCOC_DEFS_SVH
`define PCOC_DEFS_SVH

////////////////////////////////////////////////////////////////////////////
// register byte addresses
`define PCOC_ADDR_CLKOUT 32'h4000_0050
`define PCOC_ADDR_SYNTH 32'h4000_0060

////////////////////////////////////////////////////////////////////////////
// clock_output_control fields
`define PCOC_CO_EN_BIT 4
`define PCOC_CO_DIV_MSB 3
`define PCOC_CO_DIV_LSB 0
`define PCOC_CO_EN_RST 1'h0
`define PCOC_CO_DIV_RST 4'hf

////////////////////////////////////////////////////////////////////////////
// synth_control fields
`define PCOC_SC_RSTN_BIT 15
`define PCOC_SC_EN_BIT 14
`define PCOC_SC_BYP_BIT 13
`define PCOC_SC_LOCK_BIT 12
`define PCOC_SC_PRE_BIT 8
`define PCOC_SC_FB_MSB 7
`define PCOC_SC_FB_LSB 4
`define PCOC_SC_PD_MSB 2
`define PCOC_SC_PD_LSB 0
`define PCOC_SC_FB_RST 4'h0
`define PCOC_SC_PD_RST 3'h0

// reference select is bit 2 of the system clock select register
`define PCOC_REF_SEL_BIT 2

////////////////////////////////////////////////////////////////////////////
// timing
`define PCOC_PCLK_PERIOD_NS 25
`define PCOC_LOCK_TIME_NS 50000
`define PCOC_LOCK_CYCLES \
  ((`PCOC_LOCK_TIME_NS + `PCOC_PCLK_PERIOD_NS - 1) / `PCOC_PCLK_PERIOD_NS)

`endif

// ==== hdl/pcoc_pkg.sv ====
// Purpose: shared types of the synthesizer and clock output block
// Assumes: nothing beyond the defines header
// Notes: types only, constants live in pcoc_defs.svh
`default_nettype none
package pcoc_pkg;

  typedef enum logic [1:0] {
    PCOC_OFF = 2'b00,
    PCOC_ACQ = 2'b01,
    PCOC_LOCK = 2'b10
  } pcoc_lock_st_t;

  typedef logic [5:0] pcoc_ratio_t;

endpackage

`default_nettype wire

// ==== hdl/pcoc_top.sv ====
// Purpose: synthesizer control, clock model and clock output over apb
// Assumes: all clock sources are levels synchronous to pclk
// Notes: the synthesizer is a behavioural rate model, not an analog loop
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_defs.svh"

// How it works
// - clock output control is 8 bits: an enable bit and a 4-bit divider.
// - the clock output is the main clock through its own post divider.
// - the reference is internal or external oscillator, by select bit 2.
// - bit 15 low holds the synthesizer in reset and high releases it.
// - bit 13 low passes the reference, high passes the synthesized clock.
// - output rate is reference / predivider * multiplier / post divider.
// - bit 8 divides the reference by one when 0 and by two when 1.
// - multiplier codes give 4..18 step 2, 20, 24, 26, 34; rest unused.
// - post divider codes give 1, 2, 3, 4, 6, 8, 3 and 16.
module pcoc_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // apb answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock sources
  input wire logic internal_osc,
  input wire logic external_main_osc,
  input wire logic ref_select,
  input wire logic main_clock,
  // clock results and status
  output logic synth_output_clock,
  output logic clock_out_signal,
  output logic lock_flag
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic clock_out_enable_q;
  logic [3:0] clock_out_divider_q;
  logic synth_reset_n_q;
  logic synth_enable_q;
  logic bypass_q;
  logic input_predivider_q;
  logic [3:0] feedback_multiplier_q;
  logic [2:0] output_divider_q;

  // apb answer flops
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // synthesizer model
  pcoc_pkg::pcoc_lock_st_t lock_st_q;
  pcoc_pkg::pcoc_lock_st_t lock_st_d;
  logic [11:0] lock_cnt_q;
  logic [11:0] lock_cnt_d;
  logic lock_q;
  logic [8:0] cfg_q;
  logic [8:0] cfg;
  logic cfg_chg;
  logic ref_now;
  logic ref_q;
  logic ref_rise;
  logic [7:0] acc_q;
  logic [7:0] credit_add;
  logic synth_q;
  logic synth_out_q;
  logic active;
  pcoc_pkg::pcoc_ratio_t mult;
  pcoc_pkg::pcoc_ratio_t post_n;
  pcoc_pkg::pcoc_ratio_t thresh;

  // apb decode
  logic hit_co;
  logic hit_sc;
  logic setup;
  logic access;
  logic wr_co;
  logic wr_sc;
  logic [31:0] rd_mux;

  localparam logic [11:0] LockLast = 12'(`PCOC_LOCK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // ratio tables
  function automatic pcoc_pkg::pcoc_ratio_t fb_ratio(input logic [3:0] code);
    pcoc_pkg::pcoc_ratio_t m;
    m = 6'd0;
    // unused codes give zero, which stops the model and blocks lock
    unique case (code)
      4'h0: m = 6'd4;
      4'h1: m = 6'd6;
      4'h2: m = 6'd8;
      4'h3: m = 6'd10;
      4'h4: m = 6'd12;
      4'h5: m = 6'd14;
      4'h6: m = 6'd16;
      4'h7: m = 6'd18;
      4'h8: m = 6'd20;
      4'h9: m = 6'd24;
      4'ha: m = 6'd26;
      4'hb: m = 6'd34;
      4'hc, 4'hd, 4'he, 4'hf: m = 6'd0;
    endcase
    return m;
  endfunction

  function automatic pcoc_pkg::pcoc_ratio_t pd_ratio(input logic [2:0] code);
    pcoc_pkg::pcoc_ratio_t n;
    n = 6'd1;
    unique case (code)
      3'h0: n = 6'd1;
      3'h1: n = 6'd2;
      3'h2: n = 6'd3;
      3'h3: n = 6'd4;
      3'h4: n = 6'd6;
      3'h5: n = 6'd8;
      3'h6: n = 6'd3;
      3'h7: n = 6'd16;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, answer registered in the setup cycle
  assign hit_co = (paddr == `PCOC_ADDR_CLKOUT);
  assign hit_sc = (paddr == `PCOC_ADDR_SYNTH);
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_q;
  assign wr_co = access & pwrite & hit_co;
  assign wr_sc = access & pwrite & hit_sc;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_co) begin
      // upper bits of the byte read as zero
      rd_mux[`PCOC_CO_EN_BIT] = clock_out_enable_q;
      rd_mux[`PCOC_CO_DIV_MSB:`PCOC_CO_DIV_LSB] = clock_out_divider_q;
    end else if (hit_sc) begin
      rd_mux[`PCOC_SC_RSTN_BIT] = synth_reset_n_q;
      rd_mux[`PCOC_SC_EN_BIT] = synth_enable_q;
      rd_mux[`PCOC_SC_BYP_BIT] = bypass_q;
      rd_mux[`PCOC_SC_LOCK_BIT] = lock_q;
      rd_mux[`PCOC_SC_PRE_BIT] = input_predivider_q;
      rd_mux[`PCOC_SC_FB_MSB:`PCOC_SC_FB_LSB] = feedback_multiplier_q;
      rd_mux[`PCOC_SC_PD_MSB:`PCOC_SC_PD_LSB] = output_divider_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup & ~pready_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      // write data is not echoed; unmapped addresses read zero
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~(hit_co | hit_sc);
    end else if (access) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // clock output control register, byte lane 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_out_enable_q <= `PCOC_CO_EN_RST;
      clock_out_divider_q <= `PCOC_CO_DIV_RST;
    end else if (wr_co && pstrb[0]) begin
      clock_out_enable_q <= pwdata[`PCOC_CO_EN_BIT];
      clock_out_divider_q <= pwdata[`PCOC_CO_DIV_MSB:`PCOC_CO_DIV_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synth control register, byte lanes 0 and 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // held in reset and disabled until software releases it
      synth_reset_n_q <= 1'b0;
      synth_enable_q <= 1'b0;
      bypass_q <= 1'b0;
      input_predivider_q <= 1'b0;
    end else if (wr_sc && pstrb[1]) begin
      synth_reset_n_q <= pwdata[`PCOC_SC_RSTN_BIT];
      synth_enable_q <= pwdata[`PCOC_SC_EN_BIT];
      bypass_q <= pwdata[`PCOC_SC_BYP_BIT];
      input_predivider_q <= pwdata[`PCOC_SC_PRE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feedback_multiplier_q <= `PCOC_SC_FB_RST;
      output_divider_q <= `PCOC_SC_PD_RST;
    end else if (wr_sc && pstrb[0]) begin
      feedback_multiplier_q <= pwdata[`PCOC_SC_FB_MSB:`PCOC_SC_FB_LSB];
      output_divider_q <= pwdata[`PCOC_SC_PD_MSB:`PCOC_SC_PD_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference selection and ratios
  assign ref_now = ref_select ? external_main_osc : internal_osc;
  assign ref_rise = ref_now & ~ref_q;
  assign mult = fb_ratio(feedback_multiplier_q);
  assign post_n = pd_ratio(output_divider_q);
  // predivide by two doubles the consumption per output half period
  assign thresh = input_predivider_q ? 6'(post_n << 1) : post_n;
  // active needs reset released, enable set and a used multiplier code
  assign active = synth_reset_n_q & synth_enable_q & (mult != 6'd0);
  assign cfg = {ref_select, input_predivider_q, feedback_multiplier_q,
                output_divider_q};
  assign cfg_chg = (cfg != cfg_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
      cfg_q <= 9'h000;
    end else begin
      ref_q <= ref_now;
      cfg_q <= cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock tracking: a fixed settle time after any change of setup
  always_comb begin
    lock_st_d = lock_st_q;
    lock_cnt_d = lock_cnt_q;
    unique case (lock_st_q)
      pcoc_pkg::PCOC_OFF: begin
        lock_cnt_d = 12'h000;
        if (active) begin
          lock_st_d = pcoc_pkg::PCOC_ACQ;
        end
      end
      pcoc_pkg::PCOC_ACQ: begin
        if (!active) begin
          lock_st_d = pcoc_pkg::PCOC_OFF;
          lock_cnt_d = 12'h000;
        end else if (cfg_chg) begin
          lock_cnt_d = 12'h000;
        end else if (lock_cnt_q >= LockLast) begin
          lock_st_d = pcoc_pkg::PCOC_LOCK;
        end else begin
          lock_cnt_d = lock_cnt_q + 12'h001;
        end
      end
      pcoc_pkg::PCOC_LOCK: begin
        lock_cnt_d = 12'h000;
        if (!active) begin
          lock_st_d = pcoc_pkg::PCOC_OFF;
        end else if (cfg_chg) begin
          lock_st_d = pcoc_pkg::PCOC_ACQ;
        end
      end
      default: begin
        lock_st_d = pcoc_pkg::PCOC_OFF;
        lock_cnt_d = 12'h000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_st_q <= pcoc_pkg::PCOC_OFF;
      lock_cnt_q <= 12'h000;
      lock_q <= 1'b0;
    end else begin
      lock_st_q <= lock_st_d;
      lock_cnt_q <= lock_cnt_d;
      lock_q <= (lock_st_d == pcoc_pkg::PCOC_LOCK);
    end
  end

  assign lock_flag = lock_q;

  ////////////////////////////////////////////////////////////////////////
  // rate model: each reference rise adds 2*m, each toggle costs p*n,
  // so full periods per reference period are m / (p * n)
  // 2*m reaches 68, so it is built at 8 bits; the add is skipped near the
  // top to keep the credit from wrapping
  assign credit_add = (ref_rise && acc_q < 8'hb8) ?
                      {1'b0, mult, 1'b0} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 8'h00;
      synth_q <= 1'b0;
    end else if (!active) begin
      // reset or disable parks the synthesized clock low
      acc_q <= 8'h00;
      synth_q <= 1'b0;
    end else begin
      // one toggle per pclk at most, so the model saturates at pclk / 2
      if (acc_q + credit_add >= {2'b00, thresh}) begin
        acc_q <= acc_q + credit_add - {2'b00, thresh};
        synth_q <= ~synth_q;
      end else begin
        acc_q <= acc_q + credit_add;
      end
    end
  end

  // bypass clear passes the reference straight out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_out_q <= 1'b0;
    end else begin
      synth_out_q <= bypass_q ? synth_q : ref_now;
    end
  end

  assign synth_output_clock = synth_out_q;

  ////////////////////////////////////////////////////////////////////////
  // clock output path
  pcoc_clk_div u_clk_div (
    .pclk(pclk),
    .presetn(presetn),
    .en(clock_out_enable_q),
    .div(clock_out_divider_q),
    .src(main_clock),
    .out_q(clock_out_signal)
  );

endmodule

`default_nettype wire

// ==== test/pcoc_top_asserts.sv ====
// Purpose: port-level assertions for pcoc_top
// Assumes: one pclk domain; register shadows rebuilt from apb writes
// Notes: lock timing is checked with a few cycles of slack
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_defs.svh"
////////////////////////////////////////////////////////////
module pcoc_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // clocks and status
  input wire logic internal_osc,
  input wire logic external_main_osc,
  input wire logic ref_select,
  input wire logic main_clock,
  input wire logic synth_output_clock,
  input wire logic clock_out_signal,
  input wire logic lock_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, act, map, refv;
  logic [4:0] co_q;
  logic [15:0] sc_q;
  logic [8:0] cfg, cfg_q;
  logic [11:0] cnt_q;
  assign wr = psel & penable & pready & pwrite;
  assign map = paddr == `PCOC_ADDR_CLKOUT || paddr == `PCOC_ADDR_SYNTH;
  assign act = sc_q[15] & sc_q[14] & (sc_q[7:4] < 4'hc);
  assign cfg = {ref_select, sc_q[8], sc_q[7:4], sc_q[2:0]};
  assign refv = ref_select ? external_main_osc : internal_osc;
  // shadows of the control fields; an unstrobed lane keeps its bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      co_q <= 5'h0f;
      sc_q <= 16'h0000;
    end else if (wr && paddr == `PCOC_ADDR_CLKOUT && pstrb[0]) begin
      co_q <= pwdata[4:0];
    end else if (wr && paddr == `PCOC_ADDR_SYNTH) begin
      if (pstrb[1]) sc_q[15:8] <= pwdata[15:8];
      if (pstrb[0]) sc_q[7:0] <= pwdata[7:0];
    end
  end
  // cycles spent active with one unchanged setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 9'h000;
      cnt_q <= 12'h000;
    end else begin
      cfg_q <= cfg;
      if (!act || cfg != cfg_q) cnt_q <= 12'h000;
      else if (cnt_q != 12'hfff) cnt_q <= cnt_q + 12'h001;
    end
  end
////////////////////////////////////////////////////////////
  chk_ready_next:
    assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_unmapped_err:
    assert property (pready && !map |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_idle_quiet:
    assert property (!pready |-> !pslverr && prdata == 32'h0000_0000)
    else $error("answer outside the access cycle");
  chk_out_hold:
    assert property ((!co_q[4] || co_q[3:0] == 4'h0) [*3]
      |-> !clock_out_signal)
    else $error("clock output moves while off");
  chk_out_follow:
    assert property (co_q[4] && co_q[3:0] == 4'h1 && $stable(co_q) &&
      $rose(main_clock) |-> ##[1:3] $changed(clock_out_signal))
    else $error("clock output misses a main clock rise");
  chk_lock_idle:
    assert property (!act [*3] |-> !lock_flag)
    else $error("lock while synthesizer inactive");
  chk_lock_time:
    assert property ($rose(lock_flag) |->
      cnt_q >= 12'd1990 && cnt_q <= 12'd2010)
    else $error("lock reported at the wrong time");
  chk_bypass_ref:
    assert property ($past(presetn) && !$past(sc_q[13]) |->
      synth_output_clock == $past(refv))
    else $error("bypass output does not follow the reference");
endmodule

bind pcoc_top pcoc_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .internal_osc(internal_osc), .external_main_osc(external_main_osc),
  .ref_select(ref_select), .main_clock(main_clock),
  .synth_output_clock(synth_output_clock),
  .clock_out_signal(clock_out_signal), .lock_flag(lock_flag)
);
`default_nettype wire

// ==== test/pcoc_top_test.sv ====
// Purpose: directed apb bench for pcoc_top
// Assumes: oscillators and main clock are pclk-synchronous levels
// Notes: rates are judged by counting toggles with small slack
`timescale 1ns/1ps
`default_nettype none
`include "pcoc_defs.svh"
module pcoc_top_test;
  localparam logic [31:0] co_a = `PCOC_ADDR_CLKOUT;
  localparam logic [31:0] sc_a = `PCOC_ADDR_SYNTH;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic pready, pslverr, err, synth_output_clock, clock_out_signal, lock_flag;
  logic internal_osc = 0, external_main_osc = 0, ref_select = 0;
  logic main_clock = 0;
  logic [7:0] cyc = 0;
  logic [2:0] mc = 0;
  int mismatches = 0, cmp_count = 0, n, i;
  int mtab[12] = '{4, 6, 8, 10, 12, 14, 16, 18, 20, 24, 26, 34};
  int ntab[8] = '{1, 2, 3, 4, 6, 8, 3, 16};
  int ctab[3] = '{1, 2, 15};
  logic [15:0] gtab[3] = '{16'h4040, 16'h8040, 16'hc0c0};

  pcoc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_osc(internal_osc), .external_main_osc(external_main_osc),
    .ref_select(ref_select), .main_clock(main_clock),
    .synth_output_clock(synth_output_clock),
    .clock_out_signal(clock_out_signal), .lock_flag(lock_flag)
  );

  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // sources: internal period 8, external period 4, main period 6
  always @(posedge pclk) begin
    cyc <= cyc + 8'h01;
    internal_osc <= cyc[2];
    external_main_osc <= cyc[1];
    mc <= (mc == 3'd5) ? 3'd0 : mc + 3'd1;
    main_clock <= (mc < 3'd3);
  end
////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, d,
      input logic [3:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      mismatches++;
      $display("ERROR %0t: no apb answer", $time);
      finish_test;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    cmp(rd, exp);
  endtask

  // sel 1 watches the clock output, 0 the synthesizer output
  task automatic count(input logic sel, input int cycles, output int t);
    logic prev, cur;
    t = 0;
    @(negedge pclk);
    prev = sel ? clock_out_signal : synth_output_clock;
    repeat (cycles) begin
      @(negedge pclk);
      cur = sel ? clock_out_signal : synth_output_clock;
      if (cur !== prev) t++;
      prev = cur;
    end
  endtask

  // bypass only after lock, as software must
  task automatic synth(input logic [15:0] cfg, input int exp);
    int c, t;
    wr(sc_a, {16'h0000, cfg});
    repeat (3) @(negedge pclk);
    c = 0;
    while (lock_flag !== 1'b1 && c < 3000) begin
      @(negedge pclk);
      c++;
    end
    near(c, 1998, 4);
    if (c >= 3000) begin
      finish_test;
    end
    rchk(sc_a, {16'h0000, cfg | 16'h1000});
    wr(sc_a, {16'h0000, cfg | 16'h2000});
    repeat (4) @(negedge pclk);
    count(1'b0, 960, t);
    near(t, exp, 3);
  endtask
////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(co_a, 32'h0000_000f);
    rchk(sc_a, 32'h0000_0000);
    rchk(32'h4000_0054, 32'h0000_0000);
    cmp({31'h0, err}, 32'h0000_0001);
    for (i = 0; i < 2; i++) begin
      @(posedge pclk);
      ref_select <= i[0];
      count(1'b0, 400, n);
      near(n, 100 + 100 * i, 2);
    end
    wr(co_a, 32'hffff_ffff);
    rchk(co_a, 32'h0000_001f);
    for (i = 0; i < 3; i++) begin
      wr(co_a, 32'h0000_0010 | ctab[i]);
      count(1'b1, 600, n);
      near(n, 100 / ctab[i], 2);
    end
    wr(co_a, 32'h0000_0005);
    repeat (4) @(negedge pclk);
    count(1'b1, 200, n);
    near(n, 0, 0);
    cmp({31'h0, clock_out_signal}, 32'h0000_0000);
    // only lane 0 lands; bit 3 is reserved
    apb(1'b1, sc_a, 32'h0000_c0ff, 4'h1);
    rchk(sc_a, 32'h0000_00f7);
    // held in reset, disabled, or an unavailable multiplier: no lock
    for (i = 0; i < 3; i++) begin
      wr(sc_a, {16'h0000, gtab[i]});
      repeat (2100) @(negedge pclk);
      cmp({31'h0, lock_flag}, 32'h0000_0000);
    end
    for (i = 0; i < 8; i++) begin
      n = 1920 / ntab[i];
      synth(16'hc000 | {13'h0, i[2:0]}, n > 960 ? 960 : n);
    end
    for (i = 0; i < 12; i++) begin
      synth(16'hc107 | {8'h00, i[3:0], 4'h0}, 15 * mtab[i]);
    end
    finish_test;
  end
endmodule
`default_nettype wire
